//--- src/nsoc_consts.svh
`ifndef NSOC_CONSTS_SVH
`define NSOC_CONSTS_SVH
// apb byte offsets
`define NSOC_A_CTRL    12'h000
`define NSOC_A_PICKUP  12'h004
`define NSOC_A_DELAY   12'h008
`define NSOC_A_STATUS  12'h00c
`define NSOC_A_CNT     12'h010
`define NSOC_A_MINLOAD 12'h014
`define NSOC_A_EVSEL   12'h018
`define NSOC_A_STAGE   12'h01c
`define NSOC_A_REC     12'h020
`define NSOC_A_TIMEK   12'h02c
// pick-up defaults: 0.2 x In in 0.01 steps, 20 % in 0.01 % steps
`define NSOC_PU_NEG_DEF   16'h0014
`define NSOC_PU_RATIO_DEF 16'h07d0
// reset ratio 97 / 100
`define NSOC_RST_NUM 8'h61
`define NSOC_RST_DEN 8'h64
`define NSOC_REC_DEPTH 4'hc
`define NSOC_MS_NS 32'd1000000
`define NSOC_CLK_NS 32'd100
`define NSOC_MS_CYC (`NSOC_MS_NS / `NSOC_CLK_NS)
`define NSOC_BLK_MARGIN_MS 16'h0005
`endif

//--- src/nsoc_pkg.sv
package nsoc_pkg;
    typedef enum logic [2:0] {
        NSOC_MODE_ON = 3'h0, NSOC_MODE_BLOCKED = 3'h1, NSOC_MODE_TEST = 3'h2,
        NSOC_MODE_TEST_BLK = 3'h3, NSOC_MODE_OFF = 3'h4
    } nsoc_mode_t;
    typedef enum logic [1:0] {
        NSOC_F_NORMAL = 2'h0, NSOC_F_START = 2'h1, NSOC_F_TRIP = 2'h2,
        NSOC_F_BLOCKED = 2'h3
    } nsoc_force_t;
    typedef enum logic [1:0] {
        NSOC_T_INSTANT = 2'h0, NSOC_T_FIXED = 2'h1, NSOC_T_INVERSE = 2'h2,
        NSOC_T_SQUARE = 2'h3
    } nsoc_tmode_t;
    // gray codes along idle -> start -> trip
    typedef enum logic [1:0] {
        NSOC_S_IDLE = 2'b00, NSOC_S_START = 2'b01, NSOC_S_TRIP = 2'b11,
        NSOC_S_BLOCKED = 2'b10
    } nsoc_state_t;
endpackage

//--- src/nsoc_stage.sv
// Purpose: negseq_overcurrent_stage, one of four stage instances
// Assumes: sequence magnitudes arrive on sys_clk with a cycle strobe
// Notes: inverse-time curve value is supplied as a ready delay in ms
// Function
// (R1) five operating modes, default on, active mode readable.
// (R2) status override forces normal, start, trip or blocked outputs.
// (R3) supervised quantity: negative sequence per unit or neg/pos ratio.
// (R4) mode, override and quantity select are static, not grouped.
// (R5) release only below 97 % of pick-up level, both modes.
// (R6) per-unit pick-up in 0.01 In steps, default 0.2 In.
// (R7) ratio pick-up in 0.01 % steps, default 20 %.
// (R8) pick-up levels writable while the stage runs.
// (R9) block input sampled at each program cycle start.
// (R10) pick-up with no block asserts start and runs trip timing.
// (R11) pick-up with block asserts blocked, no trip timing.
// (R12) block after start clears start, release handled as reset.
// (R13) block source asserts block 5 ms before delay expires.
// (R14) instant mode trips in the same cycle as start.
// (R15) fixed delay mode trips after set delay, magnitude independent.
// (R16) inverse delay derived from measured to pick-up ratio.
// (R17) square-law delay is k over measured squared minus pick-up squared.
// (R18) on and off events for start, trip, block with selection.
// (R19) resettable start, trip, blocked counters; outputs exported.
// (R20) four independent stages with own settings and event ids.
// (R21) circular record of last 12 start, trip, blocked on events.
// (R22) record holds event, time, pre currents, fault, remaining time.
// (R23) ratio mode requires phase currents above minimum load.
// (R24) pick-up when selected quantity exceeds level, per cycle.
`include "nsoc_consts.svh"
module nsoc_stage import nsoc_pkg::*; #(
    parameter logic [1:0] STAGE_ID = 2'h0,
    parameter int REC_N = `NSOC_REC_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cycle_start,
    input wire logic block_in,
    input wire logic [15:0] negseq_per_unit,
    input wire logic [15:0] posseq_per_unit,
    input wire logic [15:0] phase_min_rms,
    input wire logic [15:0] inverse_delay_ms,
    input wire logic [15:0] pre20_current,
    input wire logic [15:0] pre200_current,
    input wire logic [15:0] zero_sequence_current,
    input wire logic [31:0] ms_timestamp,
    input wire logic [2:0] setting_group,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic start_out,
    output logic trip_out,
    output logic blocked_out,
    output logic event_valid,
    output logic [4:0] event_code
);
    typedef struct packed {
        nsoc_mode_t mode;
        nsoc_force_t force_st;
        logic force_en;
        logic ratio_sel;
        nsoc_tmode_t tmode;
        logic [15:0] pu_neg;
        logic [15:0] pu_ratio;
        logic [15:0] delay_ms;
        logic [15:0] k_mult;
        logic [15:0] min_load;
        logic [5:0] ev_sel;
        nsoc_state_t st;
        logic blk;
        logic [31:0] tmr_ms;
        logic [31:0] target_ms;
        logic [15:0] div;
        logic [7:0] cnt_start;
        logic [7:0] cnt_trip;
        logic [7:0] cnt_blk;
        logic [3:0] wr_ptr;
        logic [3:0] rd_idx;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic start_o;
        logic trip_o;
        logic blocked_o;
        logic ev_v;
        logic [4:0] ev_c;
    } nsoc_regs_t;
    nsoc_regs_t r, next_r;
    // record storage kept apart from the struct to keep it indexable
    logic [31:0] rec_time [REC_N];
    logic [31:0] rec_cur [REC_N];
    logic [31:0] rec_misc [REC_N];
    logic rec_we;
    logic [2:0] rec_kind;
    logic [2:0] ev_idx;

    logic [15:0] meas;
    logic [15:0] level;
    logic [23:0] ratio_pct;
    logic [23:0] rel_lhs;
    logic [23:0] rel_rhs;
    logic pick_raw;
    logic below_reset;
    logic load_ok;
    logic blk_eff;
    logic [31:0] sq_den;
    logic [31:0] sq_t;
    logic ms_tick;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction

    always_comb begin
        // ratio in 0.01 % units; zero positive sequence saturates high
        if (posseq_per_unit == 16'h0000) begin
            ratio_pct = 24'hffffff;
        end else begin
            ratio_pct = 24'((32'(negseq_per_unit) * 32'h2710)
                        / 32'(posseq_per_unit));
        end
        meas = r.ratio_sel ? ((ratio_pct > 24'h00ffff) ? 16'hffff
                              : ratio_pct[15:0]) : negseq_per_unit; // R3
        level = r.ratio_sel ? r.pu_ratio : r.pu_neg;
        load_ok = !r.ratio_sel || (phase_min_rms >= r.min_load); // R23
        // blocked modes act as a block that never lets go
        blk_eff = block_in || r.mode == NSOC_MODE_BLOCKED ||
                  r.mode == NSOC_MODE_TEST_BLK; // R11
        pick_raw = (meas > level) && load_ok; // R24
        rel_lhs = 24'(meas) * 24'(`NSOC_RST_DEN);
        rel_rhs = 24'(level) * 24'(`NSOC_RST_NUM);
        below_reset = (rel_lhs < rel_rhs) || !load_ok; // R5
        sq_den = 32'(negseq_per_unit) * 32'(negseq_per_unit)
                 - 32'(level) * 32'(level);
        // k in ms x pu^2 scaled by 10000 (0.01 pu steps squared)
        sq_t = (sq_den == 32'h0) ? 32'hffffffff
               : (32'(r.k_mult) * 32'h2710) / sq_den; // R17
    end

    always_comb begin
        next_r = r;
        rec_we = 1'b0;
        rec_kind = 3'h0;
        ev_idx = 3'h0;
        next_r.ev_v = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        ms_tick = (r.div == 16'(`NSOC_MS_CYC - 1));
        next_r.div = ms_tick ? 16'h0 : r.div + 16'h1;
        if (cycle_start) begin
            next_r.blk = block_in; // R9
            case (r.st)
                NSOC_S_IDLE: begin
                    if (pick_raw && blk_eff) begin
                        next_r.st = NSOC_S_BLOCKED; // R11
                    end else if (pick_raw) begin
                        next_r.st = NSOC_S_START; // R10
                        next_r.tmr_ms = 32'h0;
                        case (r.tmode)
                            NSOC_T_INSTANT: begin
                                next_r.st = NSOC_S_TRIP; // R14
                            end
                            NSOC_T_FIXED: begin
                                next_r.target_ms = 32'(r.delay_ms); // R15
                            end
                            NSOC_T_INVERSE: begin
                                next_r.target_ms = 32'(inverse_delay_ms); // R16
                            end
                            default: begin
                                next_r.target_ms = sq_t; // R17
                            end
                        endcase
                    end
                end
                NSOC_S_START: begin
                    if (blk_eff || below_reset) begin
                        next_r.st = NSOC_S_IDLE; // R12
                    end else if (r.tmr_ms >= r.target_ms) begin
                        next_r.st = NSOC_S_TRIP;
                    end
                end
                NSOC_S_TRIP: begin
                    if (blk_eff || below_reset) begin
                        next_r.st = NSOC_S_IDLE; // R12
                    end
                end
                default: begin
                    if (!blk_eff || below_reset) begin
                        next_r.st = NSOC_S_IDLE;
                    end
                end
            endcase
        end
        if (r.st == NSOC_S_START && ms_tick && !r.blk) begin
            next_r.tmr_ms = r.tmr_ms + 32'h1; // R15
        end
        if (r.mode == NSOC_MODE_OFF) begin
            next_r.st = NSOC_S_IDLE; // R1
        end
        // outputs, with override taking precedence
        next_r.start_o = (next_r.st == NSOC_S_START) ||
                         (next_r.st == NSOC_S_TRIP);
        next_r.trip_o = (next_r.st == NSOC_S_TRIP);
        next_r.blocked_o = (next_r.st == NSOC_S_BLOCKED);
        if (r.force_en && r.force_st != NSOC_F_NORMAL) begin
            next_r.start_o = (r.force_st != NSOC_F_BLOCKED); // R2
            next_r.trip_o = (r.force_st == NSOC_F_TRIP);
            next_r.blocked_o = (r.force_st == NSOC_F_BLOCKED);
        end
        // one event per cycle; any trip edge wins over a start edge, which wins over a block edge
        if (next_r.trip_o != r.trip_o) begin
            rec_kind = {1'b0, next_r.trip_o, 1'b1};
        end else if (next_r.start_o != r.start_o) begin
            rec_kind = {1'b0, next_r.start_o, 1'b0} | 3'h4;
        end else if (next_r.blocked_o != r.blocked_o) begin
            rec_kind = {1'b1, next_r.blocked_o, 1'b1};
        end
        if (rec_kind != 3'h0) begin
            // kind: bit1 = on; sel bits per event {on,off} x start,trip,blk
            ev_idx = rec_kind[2] ? {rec_kind[0], 1'b0, rec_kind[1]}
                     : {2'b01, rec_kind[1]};
            if (r.ev_sel[ev_idx]) begin
                next_r.ev_v = 1'b1; // R18
                next_r.ev_c = {STAGE_ID, rec_kind}; // R20
            end
            if (rec_kind[1]) begin
                rec_we = 1'b1; // R21
                next_r.wr_ptr = (r.wr_ptr == 4'(REC_N - 1)) ? 4'h0
                                : r.wr_ptr + 4'h1;
            end
        end
        if (next_r.start_o && !r.start_o) begin
            next_r.cnt_start = r.cnt_start + 8'h1; // R19
        end
        if (next_r.trip_o && !r.trip_o) begin
            next_r.cnt_trip = r.cnt_trip + 8'h1; // R19
        end
        if (next_r.blocked_o && !r.blocked_o) begin
            next_r.cnt_blk = r.cnt_blk + 8'h1; // R19
        end
        // apb slave, one wait state: answer in the cycle after the first access cycle
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            if (hit(paddr, `NSOC_A_CTRL)) begin
                if (pwrite) begin
                    next_r.mode = nsoc_mode_t'(pwdata[2:0]); // R4
                    next_r.force_st = nsoc_force_t'(pwdata[5:4]);
                    next_r.force_en = pwdata[6];
                    next_r.ratio_sel = pwdata[8];
                    next_r.tmode = nsoc_tmode_t'(pwdata[13:12]);
                end
                next_r.prdata = {18'h0, r.tmode, 3'h0, r.ratio_sel, 1'b0,
                                 r.force_en, r.force_st, 1'b0, r.mode};
            end else if (hit(paddr, `NSOC_A_PICKUP)) begin
                if (pwrite) begin
                    next_r.pu_neg = pwdata[15:0]; // R8
                    next_r.pu_ratio = pwdata[31:16];
                end
                next_r.prdata = {r.pu_ratio, r.pu_neg}; // R6 R7
            end else if (hit(paddr, `NSOC_A_DELAY)) begin
                if (pwrite) begin
                    next_r.delay_ms = pwdata[15:0];
                end
                next_r.prdata = {16'h0, r.delay_ms};
            end else if (hit(paddr, `NSOC_A_TIMEK)) begin
                if (pwrite) begin
                    next_r.k_mult = pwdata[15:0];
                end
                next_r.prdata = {16'h0, r.k_mult};
            end else if (hit(paddr, `NSOC_A_STATUS)) begin
                next_r.prdata = {24'h0, r.blk, r.blocked_o, r.trip_o,
                                 r.start_o, 2'h0, r.st};
            end else if (hit(paddr, `NSOC_A_CNT)) begin
                if (pwrite) begin
                    next_r.cnt_start = 8'h0; // R19
                    next_r.cnt_trip = 8'h0;
                    next_r.cnt_blk = 8'h0;
                end
                next_r.prdata = {8'h0, r.cnt_blk, r.cnt_trip, r.cnt_start};
            end else if (hit(paddr, `NSOC_A_MINLOAD)) begin
                if (pwrite) begin
                    next_r.min_load = pwdata[15:0];
                end
                next_r.prdata = {16'h0, r.min_load};
            end else if (hit(paddr, `NSOC_A_EVSEL)) begin
                if (pwrite) begin
                    next_r.ev_sel = pwdata[5:0];
                end
                next_r.prdata = {26'h0, r.ev_sel};
            end else if (hit(paddr, `NSOC_A_STAGE)) begin
                if (pwrite) begin
                    // an index past the record depth would read nothing
                    next_r.rd_idx = (pwdata[3:0] < 4'(REC_N)) ? pwdata[3:0]
                                    : 4'h0;
                end
                next_r.prdata = {20'h0, r.wr_ptr, 2'h0, STAGE_ID,
                                 r.rd_idx};
            end else if (hit(paddr, `NSOC_A_REC)) begin
                next_r.prdata = rec_misc[r.rd_idx];
            end else if (hit(paddr, `NSOC_A_REC + 12'h004)) begin
                next_r.prdata = rec_time[r.rd_idx];
            end else if (hit(paddr, `NSOC_A_REC + 12'h008)) begin
                next_r.prdata = rec_cur[r.rd_idx];
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.pu_neg <= `NSOC_PU_NEG_DEF;
            r.pu_ratio <= `NSOC_PU_RATIO_DEF;
            r.ev_sel <= 6'h3f;
        end else begin
            r <= next_r;
        end
    end

    // R22: misc word {kind, group, remaining ms low, fault current}
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < REC_N; i++) begin
                rec_time[i] <= 32'h0;
                rec_cur[i] <= 32'h0;
                rec_misc[i] <= 32'h0;
            end
        end else if (rec_we && r.wr_ptr < 4'(REC_N)) begin
            rec_time[r.wr_ptr] <= ms_timestamp; // R22
            rec_cur[r.wr_ptr] <= {pre200_current, pre20_current};
            rec_misc[r.wr_ptr] <= {rec_kind, setting_group,
                10'(r.target_ms - r.tmr_ms), negseq_per_unit};
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign start_out = r.start_o;
    assign trip_out = r.trip_o;
    assign blocked_out = r.blocked_o;
    assign event_valid = r.ev_v;
    assign event_code = r.ev_c;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_trip_implies_start: assert property (trip_out && !r.force_en
        |-> start_out) else $error("trip without start"); // R14
    a_block_no_timing: assert property (r.st == NSOC_S_BLOCKED
        |=> r.tmr_ms == $past(r.tmr_ms)) else $error("blocked timer moved"); // R11
    a_block_clears_start: assert property (cycle_start && block_in
        && r.st == NSOC_S_START && r.mode != NSOC_MODE_OFF
        |=> r.st == NSOC_S_IDLE) else $error("block kept start"); // R12
    a_off_idle: assert property (r.mode == NSOC_MODE_OFF
        |=> r.st == NSOC_S_IDLE) else $error("off mode not idle"); // R1
    a_pick_start: assert property (cycle_start && r.st == NSOC_S_IDLE
        && pick_raw && !block_in && r.mode == NSOC_MODE_ON
        |=> r.st != NSOC_S_IDLE) else $error("no start on pickup"); // R10
    a_reset_hold: assert property (cycle_start && r.st == NSOC_S_TRIP
        && !blk_eff && !below_reset && r.mode != NSOC_MODE_OFF
        |=> r.st == NSOC_S_TRIP) else $error("released above 97 pct"); // R5
    a_force_trip: assert property (r.force_en && r.force_st == NSOC_F_TRIP
        |=> trip_out) else $error("force trip ignored"); // R2
    a_apb_ready: assert property (psel && penable && !pready
        |=> pready) else $error("apb no answer"); // R8
    a_rec_ptr: assert property (r.wr_ptr < 4'(REC_N))
        else $error("record pointer out of range"); // R21
    c_trip: cover property (trip_out);
    c_blocked: cover property (blocked_out);
    c_release: cover property (start_out ##1 !start_out);
endmodule

//--- dv/nsoc_meas_model.sv
// Purpose: measurement chain and blocking matrix in front of one stage
// Assumes: the bench asks for values, the model applies them mid-cycle
// Notes: strobe period is shortened, far below a real program cycle
module nsoc_meas_model #(
    parameter int PER = 40
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] want_neg,
    input wire logic [15:0] want_pos,
    input wire logic [15:0] want_load,
    input wire logic want_blk,
    output logic cycle_start,
    output logic block_in,
    output logic [15:0] negseq_per_unit,
    output logic [15:0] posseq_per_unit,
    output logic [15:0] phase_min_rms
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            cycle_start <= 1'b0;
            block_in <= 1'b0;
            negseq_per_unit <= 16'h0000;
            posseq_per_unit <= 16'h0000;
            phase_min_rms <= 16'h0000;
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            cycle_start <= (cnt == PER - 1);
            // values move half a cycle away from the strobe, never on it
            if (cnt == PER / 2) begin
                block_in <= want_blk;
                negseq_per_unit <= want_neg;
                posseq_per_unit <= want_pos;
                phase_min_rms <= want_load;
            end
        end
    end
endmodule

//--- dv/negseq_overcurrent_stage_tb.sv
// Purpose: self-checking bench for one negative sequence stage
// Assumes: apb with one wait state, outputs registered after a strobe
// Notes: random levels come from a fixed-seed xorshift
`include "nsoc_consts.svh"
module negseq_overcurrent_stage_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, cs, blk, psel, penable, pwrite, pready, pslverr;
    logic start_out, trip_out, blocked_out, event_valid, w_blk;
    logic [15:0] neg, pos, load, w_neg, w_pos, w_load, invd, p20, p200, zs;
    logic [31:0] ts, pwdata, prdata, rq, rs;
    logic [11:0] paddr;
    logic [2:0] grp;
    logic [4:0] event_code, last_ev;
    logic re;
    int num_errors, compares;

    nsoc_meas_model nsoc_meas_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .want_neg(w_neg), .want_pos(w_pos), .want_load(w_load),
        .want_blk(w_blk), .cycle_start(cs), .block_in(blk),
        .negseq_per_unit(neg), .posseq_per_unit(pos), .phase_min_rms(load));
    nsoc_stage nsoc_stage_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .cycle_start(cs), .block_in(blk), .negseq_per_unit(neg),
        .posseq_per_unit(pos), .phase_min_rms(load),
        .inverse_delay_ms(invd), .pre20_current(p20),
        .pre200_current(p200), .zero_sequence_current(zs),
        .ms_timestamp(ts), .setting_group(grp), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out),
        .blocked_out(blocked_out), .event_valid(event_valid),
        .event_code(event_code));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        ts <= ts + 32'h1;
        if (event_valid === 1'b1) begin
            last_ev <= event_code;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // hysteresis: pick-up above level, release below 97 % of it
    function automatic logic exp_st(input logic st,
                                    input logic [15:0] v, lvl);
        if (st) begin
            return !(({16'h0, v} * 32'd100) < ({16'h0, lvl} * 32'd97));
        end
        return v > lvl;
    endfunction

    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task tmo;
        num_errors++;
        $display("[FAIL] %0t wait bound used up", $time);
        results();
    endtask

    task chk(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) tmo();
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pcyc(input int n);
        int k;
        for (int j = 0; j < n; j++) begin
            k = 0;
            do begin
                @(posedge sys_clk);
                k++;
            end while (cs !== 1'b1 && k < 500);
            if (k >= 500) tmo();
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic setin(input logic [15:0] n, input logic b);
        w_neg <= n;
        w_blk <= b;
        pcyc(2);
    endtask

    initial begin
        logic st;
        logic [15:0] v;
        int k;
        {rst_n, psel, penable, pwrite, w_blk} = 5'h0;
        {w_neg, w_pos, w_load, invd, p20, p200, zs} = '0;
        {ts, pwdata, paddr, grp, last_ev} = '0;
        rs = 32'h1a50;
        num_errors = 0;
        compares = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, `NSOC_A_CTRL, 32'h0);
        chk(rq, 32'h0, "ctrl default");
        apb(1'b0, `NSOC_A_PICKUP, 32'h0);
        chk(rq, 32'h07d00014, "pickup default");
        apb(1'b1, 12'h100, 32'hffffffff);
        chk(re, 1'b1, "unmapped refused");
        apb(1'b1, `NSOC_A_CTRL, 32'h0);
        grp <= 3'h5;
        apb(1'b0, `NSOC_A_CTRL, 32'h0);
        chk(rq, 32'h0, "ctrl after group change");
        setin(16'h0020, 1'b0);
        chk(start_out, 1'b1, "instant start");
        chk(trip_out, 1'b1, "instant trip");
        chk(last_ev, 5'b00011, "trip on event");
        setin(16'h0020, 1'b1);
        chk(start_out, 1'b0, "start cleared by block");
        setin(16'h0000, 1'b1);
        setin(16'h0020, 1'b1);
        chk(blocked_out, 1'b1, "blocked");
        chk(trip_out, 1'b0, "no trip while blocked");
        chk(last_ev, 5'b00111, "block on event");
        apb(1'b0, `NSOC_A_STATUS, 32'h0);
        chk(rq, 32'hc2, "status word");
        apb(1'b0, `NSOC_A_REC, 32'h0);
        chk(rq, 32'h74000020, "first record");
        setin(16'h0000, 1'b0);
        apb(1'b1, `NSOC_A_CTRL, 32'h4);
        setin(16'h0020, 1'b0);
        chk(start_out, 1'b0, "off mode");
        apb(1'b0, `NSOC_A_CTRL, 32'h0);
        chk(rq, 32'h4, "mode readback");
        apb(1'b1, `NSOC_A_CTRL, 32'h1);
        pcyc(2);
        chk(blocked_out, 1'b1, "blocked mode");
        apb(1'b1, `NSOC_A_CTRL, 32'h0);
        setin(16'h0000, 1'b0);
        apb(1'b1, `NSOC_A_CTRL, 32'h60);
        pcyc(2);
        chk(trip_out, 1'b1, "forced trip");
        apb(1'b1, `NSOC_A_CTRL, 32'h50);
        pcyc(2);
        chk({start_out, trip_out}, 2'b10, "forced start");
        apb(1'b1, `NSOC_A_CTRL, 32'h70);
        pcyc(2);
        chk({start_out, trip_out, blocked_out}, 3'b001, "forced block");
        apb(1'b1, `NSOC_A_MINLOAD, 32'ha);
        apb(1'b1, `NSOC_A_CTRL, 32'h100);
        w_pos <= 16'h0064;
        w_load <= 16'h0032;
        setin(16'h001e, 1'b0);
        chk(start_out, 1'b1, "ratio pickup");
        setin(16'h000f, 1'b0);
        chk(start_out, 1'b0, "ratio release");
        w_load <= 16'h0000;
        setin(16'h001e, 1'b0);
        chk(start_out, 1'b0, "below minimum load");
        setin(16'h0000, 1'b0);
        apb(1'b1, `NSOC_A_DELAY, 32'h2);
        apb(1'b1, `NSOC_A_CTRL, 32'h1000);
        setin(16'h0020, 1'b0);
        chk({start_out, trip_out}, 2'b10, "fixed delay start");
        repeat (9000) @(posedge sys_clk);
        chk(trip_out, 1'b0, "fixed delay early");
        k = 0;
        while (trip_out !== 1'b1 && k < 25000) begin
            @(posedge sys_clk);
            k++;
        end
        chk(trip_out, 1'b1, "fixed delay trip");
        // delay input and k are zero, so both curves trip one cycle on
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, `NSOC_A_CTRL, 32'(m) << 12);
            setin(16'h0000, 1'b0);
            setin(16'h0020, 1'b0);
            pcyc(1);
            chk(trip_out, 1'b1, "curve trip");
        end
        apb(1'b1, `NSOC_A_CTRL, 32'h0);
        setin(16'h0000, 1'b0);
        apb(1'b0, `NSOC_A_CNT, 32'h0);
        chk(rq !== 32'h0, 1'b1, "counters moved");
        apb(1'b1, `NSOC_A_CNT, 32'h0);
        apb(1'b0, `NSOC_A_CNT, 32'h0);
        chk(rq, 32'h0, "counters cleared");
        apb(1'b1, `NSOC_A_EVSEL, 32'h2f);
        setin(16'h0020, 1'b1);
        setin(16'h0000, 1'b0);
        chk(last_ev, 5'b00111, "block off masked");
        apb(1'b0, `NSOC_A_CNT, 32'h0);
        chk(rq, 32'h00010000, "blocked count");
        apb(1'b1, `NSOC_A_PICKUP, 32'h07d00040);
        st = 1'b0;
        for (int i = 0; i < 24; i++) begin
            rs = xs(rs);
            v = 16'h0038 + {12'h0, rs[3:0]};
            {p20, p200} <= rs;
            invd <= rs[15:0];
            zs <= rs[31:16];
            grp <= rs[6:4];
            setin(v, 1'b0);
            st = exp_st(st, v, 16'h0040);
            chk(start_out, st, "random start");
            chk(trip_out, st, "random trip");
        end
        results();
    end
endmodule
